//--- hdl/tcu_pkg.sv
// Summary of operation
// - Both compare values are checked against the 8-bit counter every timer tick.
// - A compare flag sets one tick after equality is seen.
// - Enabled flags request interrupt; cleared by service or writing one.
// - PWM modes buffer compare values; normal and clear modes write directly.
// - Buffered compare values load only at top or bottom of the count.
// - Compare register access hits buffer when buffered, active value otherwise.
// - Force strobe acts like a match on the output only, no flag or counter effect; ignored in PWM modes.
// - Counter write suppresses matches other than the CTC clear in the next timer tick, even when stopped.
// - Output state survives waveform mode changes.
// - Output action bits are unbuffered; apply at next match or force.
// - Nonzero action bits route output state to the pin; direction bit still rules.
// - Pin override works the same in every waveform mode.
// - Action setting zero leaves output state untouched on matches.
// - Only the mode field shapes counting; action bits never do.
// - PWM: action picks polarity; non-PWM: set, clear or toggle.
// - Mode zero counts up forever, wrapping 0xFF to 0x00.
// - Free-running overflow flag sets as counter becomes zero.
// - Free-running counter accepts software writes at any time.
// - Counter write beats count or clear; clock select zero stops it.
// - Bottom is 0x00, max 0xFF, top is 0xFF or compare A.
package tcu_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] TCU_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCU_OFS_OUTC = 8'h04;
  localparam logic [7:0] TCU_OFS_PORT = 8'h08;
  localparam logic [7:0] TCU_OFS_CNT  = 8'h0C;
  localparam logic [7:0] TCU_OFS_CMPA = 8'h10;
  localparam logic [7:0] TCU_OFS_CMPB = 8'h14;
  localparam logic [7:0] TCU_OFS_FLAG = 8'h18;
  localparam logic [7:0] TCU_OFS_IEN  = 8'h1C;
  localparam logic [7:0] TCU_OFS_STAT = 8'h20;

  // ==========================================================
  // Field positions
  localparam int TCU_CTRL_WGM_LSB = 0;
  localparam int TCU_CTRL_CS_LSB  = 3;
  localparam int TCU_OUTC_COM_LSB = 0;
  localparam int TCU_OUTC_FOC_LSB = 4;
  localparam int TCU_PORT_VAL_LSB = 0;
  localparam int TCU_PORT_DIR_LSB = 2;
  localparam int TCU_FLAG_OVF     = 0;
  localparam int TCU_FLAG_MA      = 1;
  localparam int TCU_STAT_DN      = 2;

  // ==========================================================
  // Constants and reset values
  localparam logic [7:0] TCU_BOTTOM   = 8'h00;
  localparam logic [7:0] TCU_MAX      = 8'hFF;
  localparam logic [7:0] TCU_RST_BYTE = 8'h00;
  localparam logic [2:0] TCU_CS_STOP  = 3'h0;
  localparam logic [1:0] TCU_COM_NONE = 2'h0;
  localparam logic [1:0] TCU_COM_TGL  = 2'h1;

  // Low two mode bits pick the counting style
  typedef enum logic [1:0] {
    TCU_K_NORMAL = 2'b00,
    TCU_K_PHASE  = 2'b01,
    TCU_K_FAST   = 2'b11,
    TCU_K_CTC    = 2'b10
  } tcu_kind_t;

  typedef struct packed {
    logic [7:0]       cnt;
    logic             dn;
    logic             blk;
    logic [1:0][7:0]  ocr;
    logic [1:0][7:0]  buf_v;
    logic [2:0]       wgm;
    logic [2:0]       cs;
    logic [1:0][1:0]  com;
    logic [1:0]       port;
    logic [1:0]       ddr;
    logic [1:0]       oc;
    logic [2:0]       flg;
    logic [2:0]       ien;
    logic [2:0]       irq;
    logic [1:0]       pin;
    logic [1:0]       pin_oe_n;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } tcu_state_t;

endpackage : tcu_pkg

//--- hdl/tcu_top.sv
// The placing of the registers and the APB register port were decided locally.
module tcu_top
  import tcu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  irq_ack,
  output logic [2:0]       irq_req,
  output logic [1:0]       pin_o,
  output logic [1:0]       pin_oe_n
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] top_of(input logic [2:0] wgm,
                                        input logic [7:0] ocr_a);
    top_of = wgm[2] ? ocr_a : TCU_MAX;
  endfunction

  // New output state for an action; v is the level for setting 2
  function automatic logic act(input logic [1:0] com,
                               input logic       oc,
                               input logic       v);
    case (com)
      TCU_COM_NONE: act = oc;
      TCU_COM_TGL:  act = ~oc;
      2'h2:         act = v;
      default:      act = ~v;
    endcase
  endfunction

  tcu_state_t s_q;
  tcu_state_t s_d;

  logic       wr;
  logic       wr_cnt;
  logic       wr_outc;
  logic       tick;
  logic       pwm;
  logic       at_top;
  logic [7:0] top;
  logic [1:0] match;
  tcu_kind_t  kind;

  assign wr      = psel & penable & s_q.pready & pwrite;
  assign wr_cnt  = wr & (paddr == TCU_OFS_CNT);
  assign wr_outc = wr & (paddr == TCU_OFS_OUTC);
  assign tick    = (s_q.cs != TCU_CS_STOP);
  assign kind    = tcu_kind_t'(s_q.wgm[1:0]);
  assign pwm     = s_q.wgm[0];
  assign top     = top_of(s_q.wgm, s_q.ocr[0]);
  assign at_top  = (s_q.cnt == top);

  // Comparator; a counter write blanks the next tick
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match[i] = tick & ~s_q.blk & (s_q.cnt == s_q.ocr[i]);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Clears go first so that a set later in this process wins the same cycle
    for (int f = 0; f < 3; f++) begin
      if (irq_ack[f] || (wr && paddr == TCU_OFS_FLAG && pwdata[f])) begin
        s_d.flg[f] = 1'b0;
      end
    end

    // Counting
    if (tick) begin
      s_d.blk = 1'b0;
      case (kind)
        TCU_K_NORMAL: begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == TCU_MAX) begin
            s_d.flg[TCU_FLAG_OVF] = 1'b1;
          end
        end
        TCU_K_CTC: begin
          if (match[0] || (s_q.blk && s_q.cnt == s_q.ocr[0])) begin
            s_d.cnt = TCU_BOTTOM;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == TCU_MAX) begin
              s_d.flg[TCU_FLAG_OVF] = 1'b1;
            end
          end
        end
        TCU_K_FAST: begin
          if (at_top) begin
            s_d.cnt = TCU_BOTTOM;
            s_d.flg[TCU_FLAG_OVF] = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
        default: begin
          if (s_q.dn) begin
            if (s_q.cnt == TCU_BOTTOM) begin
              s_d.dn  = 1'b0;
              s_d.cnt = s_q.cnt + 8'h01;
            end else begin
              s_d.cnt = s_q.cnt - 8'h01;
              if (s_q.cnt == 8'h01) begin
                s_d.flg[TCU_FLAG_OVF] = 1'b1;
              end
            end
          end else if (at_top) begin
            s_d.dn  = 1'b1;
            s_d.cnt = s_q.cnt - 8'h01;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      endcase
      // Fast loads as it wraps to bottom, phase correct at top
      if (pwm && at_top) begin
        s_d.ocr = s_q.buf_v;
      end
    end
    if (!pwm) begin
      s_d.dn = 1'b0;
    end

    // Output state per channel; mode change leaves it alone
    for (int i = 0; i < 2; i++) begin
      if (match[i]) begin
        s_d.flg[TCU_FLAG_MA + i] = 1'b1;
        if (kind == TCU_K_PHASE) begin
          s_d.oc[i] = act(s_q.com[i], s_q.oc[i], s_q.dn);
        end else begin
          s_d.oc[i] = act(s_q.com[i], s_q.oc[i], 1'b0);
        end
      end else if (tick && kind == TCU_K_FAST && at_top && s_q.com[i][1]) begin
        s_d.oc[i] = act(s_q.com[i], s_q.oc[i], 1'b1);
      end
      // Force applies the action written with it, on the output only
      if (wr_outc && !pwm && pwdata[TCU_OUTC_FOC_LSB + i]) begin
        s_d.oc[i] = act(pwdata[TCU_OUTC_COM_LSB + 2 * i +: 2], s_q.oc[i], 1'b0);
      end
    end

    // Register writes; counter write wins over counting
    if (wr) begin
      if (paddr == TCU_OFS_CTRL) begin
        s_d.wgm = pwdata[TCU_CTRL_WGM_LSB +: 3];
        s_d.cs  = pwdata[TCU_CTRL_CS_LSB +: 3];
      end else if (paddr == TCU_OFS_OUTC) begin
        s_d.com[0] = pwdata[TCU_OUTC_COM_LSB +: 2];
        s_d.com[1] = pwdata[TCU_OUTC_COM_LSB + 2 +: 2];
      end else if (paddr == TCU_OFS_PORT) begin
        s_d.port = pwdata[TCU_PORT_VAL_LSB +: 2];
        s_d.ddr  = pwdata[TCU_PORT_DIR_LSB +: 2];
      end else if (paddr == TCU_OFS_CNT) begin
        s_d.cnt = pwdata[7:0];
        s_d.blk = 1'b1;
      end else if (paddr == TCU_OFS_CMPA || paddr == TCU_OFS_CMPB) begin
        if (paddr == TCU_OFS_CMPA) begin
          s_d.buf_v[0] = pwdata[7:0];
          if (!pwm) begin
            s_d.ocr[0] = pwdata[7:0];
          end
        end else begin
          s_d.buf_v[1] = pwdata[7:0];
          if (!pwm) begin
            s_d.ocr[1] = pwdata[7:0];
          end
        end
      end else if (paddr == TCU_OFS_IEN) begin
        s_d.ien = pwdata[2:0];
      end
    end

    s_d.irq = s_d.flg & s_d.ien;

    // Pin override, independent of mode
    for (int i = 0; i < 2; i++) begin
      s_d.pin[i]      = (s_d.com[i] != TCU_COM_NONE) ? s_d.oc[i] : s_d.port[i];
      s_d.pin_oe_n[i] = ~s_d.ddr[i];
    end

    // APB: read data captured in setup, zero-wait access
    s_d.pready  = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      if (paddr == TCU_OFS_CTRL) begin
        s_d.prdata[5:0] = {s_q.cs, s_q.wgm};
      end else if (paddr == TCU_OFS_OUTC) begin
        s_d.prdata[3:0] = {s_q.com[1], s_q.com[0]};
      end else if (paddr == TCU_OFS_PORT) begin
        s_d.prdata[3:0] = {s_q.ddr, s_q.port};
      end else if (paddr == TCU_OFS_CNT) begin
        s_d.prdata[7:0] = s_q.cnt;
      end else if (paddr == TCU_OFS_CMPA) begin
        s_d.prdata[7:0] = pwm ? s_q.buf_v[0] : s_q.ocr[0];
      end else if (paddr == TCU_OFS_CMPB) begin
        s_d.prdata[7:0] = pwm ? s_q.buf_v[1] : s_q.ocr[1];
      end else if (paddr == TCU_OFS_FLAG) begin
        s_d.prdata[2:0] = s_q.flg;
      end else if (paddr == TCU_OFS_IEN) begin
        s_d.prdata[2:0] = s_q.ien;
      end else if (paddr == TCU_OFS_STAT) begin
        s_d.prdata[TCU_STAT_DN:0] = {s_q.dn, s_q.oc};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.pin_oe_n <= 2'b11;
      s_q.cnt      <= TCU_RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign irq_req  = s_q.irq;
  assign pin_o    = s_q.pin;
  assign pin_oe_n = s_q.pin_oe_n;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MATCH_FLAG: assert property (
    match[0] |=> s_q.flg[TCU_FLAG_MA])
    else $error("match A did not set its flag");

  AST_FORCE_NO_FLAG: assert property (
    (wr_outc && !pwm && pwdata[TCU_OUTC_FOC_LSB] && !match[0]
     && !s_q.flg[TCU_FLAG_MA]) |=> !s_q.flg[TCU_FLAG_MA])
    else $error("force strobe set the match flag");

  AST_WRITE_BLOCK: assert property (
    wr_cnt |=> (match == 2'b00))
    else $error("match not blocked after counter write");

  AST_WRAP: assert property (
    (tick && kind == TCU_K_NORMAL && s_q.cnt == TCU_MAX && !wr_cnt)
    |=> (s_q.cnt == TCU_BOTTOM) && s_q.flg[TCU_FLAG_OVF])
    else $error("normal mode wrap or overflow flag wrong");

  AST_STOPPED: assert property (
    (!tick && !wr_cnt) |=> $stable(s_q.cnt))
    else $error("counter moved while stopped");

  AST_PIN_SRC: assert property (
    ##1 pin_o[1] == ((s_q.com[1] != TCU_COM_NONE) ? s_q.oc[1] : s_q.port[1]))
    else $error("pin B source wrong");

  AST_DBUF: assert property (
    (pwm && wr && paddr == TCU_OFS_CMPA && !(tick && at_top))
    |=> s_q.ocr[0] == $past(s_q.ocr[0]))
    else $error("buffered compare changed active value early");

  AST_COM_NONE: assert property (
    (s_q.com[0] == TCU_COM_NONE && !wr_outc) |=> $stable(s_q.oc[0]))
    else $error("output state changed with action zero");

  AST_IRQ: assert property (
    irq_req == (s_q.flg & s_q.ien))
    else $error("interrupt request mismatch");

  // ==========================================================
  // Counter and flag checks
  AST_MATCH_FLAG_B: assert property (
    match[1] |=> s_q.flg[TCU_FLAG_MA + 1])
    else $error("match B did not set its flag");

  AST_FLAG_ACK: assert property (
    (irq_ack[TCU_FLAG_MA] && !match[0]) |=> !s_q.flg[TCU_FLAG_MA])
    else $error("service did not clear flag A");

  AST_FLAG_W1C: assert property (
    (wr && paddr == TCU_OFS_FLAG && pwdata[TCU_FLAG_MA + 1] && !match[1])
    |=> !s_q.flg[TCU_FLAG_MA + 1])
    else $error("write one did not clear flag B");

  AST_OVF_QUIET: assert property (
    (tick && kind == TCU_K_NORMAL && s_q.cnt != TCU_MAX && !s_q.flg[TCU_FLAG_OVF])
    |=> !s_q.flg[TCU_FLAG_OVF])
    else $error("overflow flag set away from the wrap");

  AST_COUNT_UP: assert property (
    (tick && kind == TCU_K_NORMAL && !wr_cnt) |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("normal mode did not count up by one");

  AST_UP_ONLY: assert property (
    !pwm |=> !s_q.dn)
    else $error("count direction turned outside PWM");

  AST_CNT_WRITE: assert property (
    wr_cnt |=> s_q.cnt == $past(pwdata[7:0]))
    else $error("counter write lost to counting");

  AST_BLOCK_HOLD: assert property (
    (s_q.blk && !tick) |=> s_q.blk)
    else $error("match blocking released while stopped");

  // ==========================================================
  // Compare value and output state checks
  AST_DIRECT_B: assert property (
    (!pwm && wr && paddr == TCU_OFS_CMPB) |=> s_q.ocr[1] == $past(pwdata[7:0]))
    else $error("compare B write did not reach active value");

  AST_BUF_LOAD: assert property (
    (pwm && tick && at_top) |=> s_q.ocr == $past(s_q.buf_v))
    else $error("buffered compare values not loaded at top");

  AST_FORCE_PWM: assert property (
    (wr_outc && pwm && !match[0] && !(tick && kind == TCU_K_FAST && at_top))
    |=> $stable(s_q.oc[0]))
    else $error("force strobe acted in a PWM mode");

  AST_FORCE_OUT: assert property (
    (wr_outc && !pwm && pwdata[TCU_OUTC_FOC_LSB]
     && pwdata[TCU_OUTC_COM_LSB +: 2] == TCU_COM_TGL)
    |=> s_q.oc[0] != $past(s_q.oc[0]))
    else $error("force strobe did not toggle output A");

  AST_MODE_KEEP: assert property (
    (wr && paddr == TCU_OFS_CTRL && !tick) |=> $stable(s_q.oc[1]))
    else $error("output state changed with the mode");

  // ==========================================================
  // Pin and bus checks
  AST_PIN_SRC_A: assert property (
    pin_o[0] == ((s_q.com[0] != TCU_COM_NONE) ? s_q.oc[0] : s_q.port[0]))
    else $error("pin A source wrong");

  AST_PIN_OE: assert property (
    pin_oe_n == ~s_q.ddr)
    else $error("pin enable does not follow direction");

  AST_PREADY: assert property (
    (psel && !penable) |=> pready)
    else $error("no ready in the access cycle");

  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  AST_ERR_READY: assert property (
    pslverr |-> pready)
    else $error("error shown without ready");

  AST_RDATA_IDLE: assert property (
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data not zero outside access");

  AST_FORCE_RD: assert property (
    (psel && !penable && paddr == TCU_OFS_OUTC) |=> (prdata[5:4] == 2'b00))
    else $error("force strobes read back nonzero");

endmodule : tcu_top

//--- testbench/tb_top.sv
module tb_top;
  import tcu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  irq_ack = 3'h0;
  logic [2:0]  irq_req;
  logic [1:0]  pin_o, pin_oe_n, pin_lvl;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #5 pclk = ~pclk;

  tcu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n));

  tcu_cpu_model cpu_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl));

  // ==========================================================
  // Shared helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    cpu_u.xfer(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    cpu_u.xfer(a, 1'b0, 32'h0, d, e);
  endtask

  // Bounded wait, cycles counted after the launching edge
  task automatic wait_irq(input int i, output int n);
    n = 0;
    while (irq_req[i] !== 1'b1 && n < 400) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_overflow();
    int n;
    wr(TCU_OFS_IEN, 32'h1);
    wr(TCU_OFS_CNT, 32'hFD);
    wr(TCU_OFS_CTRL, 32'h08);
    wait_irq(0, n);
    chk("ovf delay", 1, n inside {[3:4]});
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge pclk);
    chk("ovf after ack", 0, irq_req[0]);
    wr(TCU_OFS_CTRL, 32'h0);
    wr(TCU_OFS_FLAG, 32'h7);
    $display("test overflow done");
  endtask

  task automatic t_match();
    int n;
    logic [31:0] d;
    wr(TCU_OFS_CMPA, 32'h5);
    wr(TCU_OFS_CMPB, 32'h7);
    wr(TCU_OFS_CNT, 32'h5);
    wr(TCU_OFS_FLAG, 32'h7);
    wr(TCU_OFS_IEN, 32'h6);
    wr(TCU_OFS_CTRL, 32'h08);
    wait_irq(2, n);
    chk("match b delay", 1, n inside {[2:4]});
    chk("blocked a", 0, irq_req[1]);
    wait_irq(1, n);
    chk("match a wrap", 1, n inside {[248:258]});
    wr(TCU_OFS_CTRL, 32'h0);
    wr(TCU_OFS_FLAG, 32'h2);
    rd(TCU_OFS_FLAG, d);
    chk("flag a w1c", 0, d[1]);
    rd(TCU_OFS_STAT, d);
    chk("no action", 0, d[0]);
    $display("test match done");
  endtask

  task automatic t_force();
    logic [31:0] d;
    logic [1:0]  act [3] = '{2'h1, 2'h2, 2'h3};
    logic        ex  [3] = '{1'b1, 1'b0, 1'b1};
    // Output state is prepared before the pin is turned to output
    wr(TCU_OFS_OUTC, 32'h12);
    wr(TCU_OFS_PORT, 32'h4);
    for (int i = 0; i < 3; i++) begin
      wr(TCU_OFS_OUTC, {28'h1, 2'h0, act[i]});
      rd(TCU_OFS_STAT, d);
      chk("forced state", ex[i], d[0]);
      chk("pin level", ex[i], pin_lvl[0]);
    end
    rd(TCU_OFS_OUTC, d);
    chk("outc read", 32'h3, d);
    rd(TCU_OFS_FLAG, d);
    chk("force no flag", 0, d[1]);
    wr(TCU_OFS_OUTC, 32'h10);
    rd(TCU_OFS_STAT, d);
    chk("zero action", 1, d[0]);
    chk("port value", 0, pin_lvl[0]);
    wr(TCU_OFS_CTRL, 32'h3);
    wr(TCU_OFS_OUTC, 32'h12);
    rd(TCU_OFS_STAT, d);
    chk("kept on mode", 1, d[0]);
    chk("pwm pin", 1, pin_lvl[0]);
    wr(TCU_OFS_CTRL, 32'h0);
    $display("test force done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    cpu_u.xfer(8'h24, 1'b0, 32'h0, d, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, d);
    $display("test unmapped done");
  endtask

  // ==========================================================
  // Run and watchdog
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    logic [31:0] d;
    repeat (5) @(posedge pclk);
    chk("oe in reset", 32'h3, {30'h0, pin_oe_n});
    presetn <= 1'b1;
    rd(TCU_OFS_CNT, d);
    chk("cnt reset", 32'h0, d);
    t_overflow();
    t_match();
    t_force();
    t_unmapped();
    test_done();
  end
endmodule // tb_top

//--- testbench/tcu_cpu_model.sv
// ==========================================================
// CPU register side and port pin of the timer block
module tcu_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [1:0]  pin_o,
  input  wire logic [1:0]  pin_oe_n,
  output logic [1:0]       pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Released pin floats up through the pad pull-up
  assign pin_lvl = pin_o | pin_oe_n;

  // Writes may come at any moment, counting or not
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // tcu_cpu_model
